// ---- rtl/can_mode_step.sv ----
// Purpose: automatic transceiver mode change on low-power and fail-safe entry
// Assumes: one-cycle entry strobes from the mode state machine
// Notes:   only the two low mode bits are ever changed here
`timescale 1ns/10ps
`include "wdbus_regs.svh"
module can_mode_step
	import wdbus_pkg::*;
(
	input  wire logic [1:0] mode_lo_i,
	input  wire logic       sleep_entry_i,
	input  wire logic       stop_entry_i,
	input  wire logic       failsafe_entry_i,
	input  wire logic       system_error_flag_i,
	output logic            change_o,
	output logic [1:0]      mode_lo_o
);

	// fail-safe wins: the device must stay wakeable
	always_comb begin
		change_o  = 1'b0;
		mode_lo_o = mode_lo_i;
		if (failsafe_entry_i) begin
			change_o  = 1'b1;
			mode_lo_o = `CAN_MODE_WAKE;
		end else if (sleep_entry_i && !system_error_flag_i && mode_lo_i == `CAN_MODE_NORMAL) begin
			change_o  = 1'b1;
			mode_lo_o = `CAN_MODE_WAKE;
		end else if (sleep_entry_i && mode_lo_i == `CAN_MODE_RX) begin
			change_o  = 1'b1;
			mode_lo_o = `CAN_MODE_WAKE;
		end else if (stop_entry_i) begin
			// stop entry keeps normal, receive-only, wake and off as they are
			change_o  = 1'b0;
			mode_lo_o = mode_lo_i;
		end
	end

endmodule : can_mode_step

// ---- rtl/wdbus_ctrl_regs.sv ----
// Purpose: watchdog control, transceiver mode and peak-threshold registers on SPI
// Assumes: SPI frames already decoded to one-cycle read/write strobes on core_clk_i
// Notes:   restart and soft reset are one-cycle strobes from the mode state machine
`timescale 1ns/10ps
`include "wdbus_regs.svh"

module wdbus_ctrl_regs
	import wdbus_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire spi_req_s   spi_req_i,
	output logic [7:0]      spi_rdata_o,
	output logic            spi_fail_o,
	input  wire sbc_mode_e  sbc_mode_i,
	input  wire logic       soft_reset_i,
	input  wire logic       restart_entry_i,
	input  wire logic [2:0] restart_can_mode_i,
	input  wire logic       sleep_entry_i,
	input  wire logic       stop_entry_i,
	input  wire logic       failsafe_entry_i,
	input  wire logic       system_error_flag_i,
	input  wire logic       stop_watchdog_disable_hi_i,
	input  wire logic       can_wake_i,
	input  wire logic       wake_event_i,
	input  wire logic       status_event_i,
	input  wire wd_hw_upd_s wd_hw_upd_i,
	output wd_cfg_s         wd_cfg_o,
	output logic            watchdog_run_o,
	output logic            watchdog_long_window_o,
	output can_dec_s        can_dec_o,
	output logic            active_peak_threshold_sel_o,
	output logic [7:0]      external_wake_source_o,
	output logic            int_request_o
);

	logic [7:0] watchdog_control_r;
	logic [7:0] watchdog_control_nxt;
	logic [7:0] bus_mode_r;
	logic [7:0] bus_mode_nxt;
	logic [7:0] bus_peak_r;
	logic [7:0] bus_peak_nxt;
	logic [7:0] ext_wake_r;
	logic [7:0] ext_wake_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       fail_r;
	logic       fail_nxt;
	logic       wd_long_r;
	logic       wd_long_nxt;
	logic       int_r;
	logic       int_nxt;
	logic       step_change;
	logic [1:0] step_mode_lo;

	// address match used by every write path
	function automatic logic wr_hit(input spi_req_s req, input logic [6:0] addr);
		wr_hit = req.wr && (req.addr == addr);
	endfunction : wr_hit

	// full decode of the three-bit transceiver mode
	function automatic can_dec_s decode_can(input logic [2:0] mode);
		can_dec_s d;
		d                = '0;
		d.selective_wake = mode[2];
		unique case (mode[1:0])
			2'h0: d.active       = 1'b0;
			2'h1: d.wake_capable = 1'b1;
			2'h2: d.rx_only      = 1'b1;
			2'h3: d.normal       = 1'b1;
		endcase
		d.active = (mode[1:0] != 2'h0);
		return d;
	endfunction : decode_can

	can_mode_step u_step (
		.mode_lo_i           (bus_mode_r[1:0]),
		.sleep_entry_i       (sleep_entry_i),
		.stop_entry_i        (stop_entry_i),
		.failsafe_entry_i    (failsafe_entry_i),
		.system_error_flag_i (system_error_flag_i),
		.change_o            (step_change),
		.mode_lo_o           (step_mode_lo)
	);

	// register next values: reset cause first, then hardware, then software
	always_comb begin
		watchdog_control_nxt  = watchdog_control_r;
		bus_mode_nxt = bus_mode_r;
		bus_peak_nxt = bus_peak_r;
		ext_wake_nxt = ext_wake_r;
		fail_nxt     = 1'b0;
		if (soft_reset_i) begin
			watchdog_control_nxt  = `WATCHDOG_CONTROL_POR;
			bus_mode_nxt = `BUS_MODE_POR;
			bus_peak_nxt = `BUS_PEAK_POR;
			ext_wake_nxt = `EXT_WAKE_POR;
		end else if (restart_entry_i) begin
			watchdog_control_nxt[`WD_STOP_DIS_BIT] = 1'b0;
			watchdog_control_nxt[3:0]              = {1'b0, `WATCHDOG_PERIOD_FIELD_RESTART};
			bus_mode_nxt = {5'h00, restart_can_mode_i};
			bus_peak_nxt = bus_peak_r & (8'h01 << `BUS_PEAK_BIT);
		end else begin
			// hardware-updated bits land here and read back directly
			if (wd_hw_upd_i.timer_we)
				watchdog_control_nxt[2:0] = wd_hw_upd_i.timer_val;
			if (wd_hw_upd_i.stop_dis_we)
				watchdog_control_nxt[`WD_STOP_DIS_BIT] = wd_hw_upd_i.stop_dis_val;
			if (wd_hw_upd_i.bus_wake_we)
				watchdog_control_nxt[`WD_BUS_WAKE_BIT] = wd_hw_upd_i.bus_wake_val;
			if (step_change)
				bus_mode_nxt[1:0] = step_mode_lo;
			if (failsafe_entry_i)
				ext_wake_nxt = (ext_wake_r & `EXT_WAKE_FS_KEEP) | `EXT_WAKE_FS_SET;
			// software writes; a same-cycle hardware event is overridden, except fail-safe entry, which blocks mode and wake-source writes
			if (wr_hit(spi_req_i, `WATCHDOG_CONTROL_ADDR))
				watchdog_control_nxt = spi_req_i.wdata & `WATCHDOG_CONTROL_WMASK;
			if (wr_hit(spi_req_i, `BUS_MODE_ADDR) && !failsafe_entry_i)
				bus_mode_nxt = spi_req_i.wdata & `BUS_MODE_WMASK;
			if (wr_hit(spi_req_i, `EXT_WAKE_ADDR) && !failsafe_entry_i)
				ext_wake_nxt = spi_req_i.wdata & `EXT_WAKE_WMASK;
			if (wr_hit(spi_req_i, `BUS_PEAK_ADDR)) begin
				// stop mode: silently dropped, no failure flag
				if (sbc_mode_i == SBC_INIT || sbc_mode_i == SBC_NORMAL)
					bus_peak_nxt = spi_req_i.wdata & (8'h01 << `BUS_PEAK_BIT);
				else if (sbc_mode_i != SBC_STOP)
					fail_nxt = 1'b1;
			end
		end
	end

	// register bank state
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			watchdog_control_r  <= `WATCHDOG_CONTROL_POR;
			bus_mode_r <= `BUS_MODE_POR;
			bus_peak_r <= `BUS_PEAK_POR;
			ext_wake_r <= `EXT_WAKE_POR;
			fail_r     <= 1'b0;
		end else begin
			watchdog_control_r  <= watchdog_control_nxt;
			bus_mode_r <= bus_mode_nxt;
			bus_peak_r <= bus_peak_nxt;
			ext_wake_r <= ext_wake_nxt;
			fail_r     <= fail_nxt;
		end
	end

	// read mux; reserved bits are already zero in the stored values
	always_comb begin
		rdata_nxt = rdata_r;
		if (spi_req_i.rd) begin
			unique case (spi_req_i.addr)
				`WATCHDOG_CONTROL_ADDR:  rdata_nxt = watchdog_control_r;
				`BUS_MODE_ADDR: rdata_nxt = bus_mode_r;
				`BUS_PEAK_ADDR: rdata_nxt = bus_peak_r;
				`EXT_WAKE_ADDR: rdata_nxt = ext_wake_r;
				default:        rdata_nxt = 8'h00;
			endcase
		end
	end

	// watchdog long-window start after a bus wake in stop mode
	always_comb begin
		wd_long_nxt = wd_long_r;
		if (sbc_mode_i != SBC_STOP)
			wd_long_nxt = 1'b0;
		else if (can_wake_i && watchdog_control_r[`WD_BUS_WAKE_BIT])
			wd_long_nxt = 1'b1;
	end

	// interrupt: wake always, other status only with global setting
	always_comb begin
		int_nxt = wake_event_i || (status_event_i && ext_wake_r[`INT_GLOBAL_BIT]);
	end

	// answer, window and interrupt flip-flops
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rdata_r   <= 8'h00;
			wd_long_r <= 1'b0;
			int_r     <= 1'b0;
		end else begin
			rdata_r   <= rdata_nxt;
			wd_long_r <= wd_long_nxt;
			int_r     <= int_nxt;
		end
	end

	// configuration outputs toward the timer, transceiver and regulator
	always_comb begin
		wd_cfg_o.parity_ok         = ~^watchdog_control_r;
		wd_cfg_o.stop_disable      = watchdog_control_r[`WD_STOP_DIS_BIT];
		wd_cfg_o.window_type       = watchdog_control_r[`WD_TYPE_BIT];
		wd_cfg_o.start_on_bus_wake = watchdog_control_r[`WD_BUS_WAKE_BIT];
		wd_cfg_o.period            = watchdog_control_r[2:0];
	end

	// stop mode halts the watchdog only if both disable bits agree, unless a bus wake restarted it
	assign watchdog_run_o = (sbc_mode_i != SBC_STOP) || wd_long_r ||
		!(watchdog_control_r[`WD_STOP_DIS_BIT] && stop_watchdog_disable_hi_i);
	assign watchdog_long_window_o      = wd_long_r;
	assign can_dec_o                   = decode_can(bus_mode_r[2:0]);
	assign active_peak_threshold_sel_o = bus_peak_r[`BUS_PEAK_BIT];
	assign external_wake_source_o      = ext_wake_r;
	assign spi_rdata_o                 = rdata_r;
	assign spi_fail_o                  = fail_r;
	assign int_request_o               = int_r;

endmodule : wdbus_ctrl_regs

// ---- rtl/wdbus_pkg.sv ----
// Purpose: types shared by the watchdog and bus-mode register bank
// Assumes: 8-bit SPI register frames
// Notes:   constants live in wdbus_regs.svh
package wdbus_pkg;

	typedef enum logic [2:0] {
		SBC_INIT    = 3'h0,
		SBC_NORMAL  = 3'h1,
		SBC_STOP    = 3'h2,
		SBC_SLEEP   = 3'h3,
		SBC_RESTART = 3'h4,
		SBC_FAILSAFE = 3'h5
	} sbc_mode_e;

	typedef enum logic [2:0] {
		CAN_OFF      = 3'h0,
		CAN_WAKE     = 3'h1,
		CAN_RX_ONLY  = 3'h2,
		CAN_NORMAL   = 3'h3,
		CAN_OFF_SWK  = 3'h4,
		CAN_WAKE_SWK = 3'h5,
		CAN_RX_SWK   = 3'h6,
		CAN_NORM_SWK = 3'h7
	} can_mode_e;

	// one SPI register access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} spi_req_s;

	// watchdog configuration to the timer
	typedef struct packed {
		logic       parity_ok;
		logic       stop_disable;
		logic       window_type;
		logic       start_on_bus_wake;
		logic [2:0] period;
	} wd_cfg_s;

	// hardware-side updates of rwh bits
	typedef struct packed {
		logic       timer_we;
		logic [2:0] timer_val;
		logic       stop_dis_we;
		logic       stop_dis_val;
		logic       bus_wake_we;
		logic       bus_wake_val;
	} wd_hw_upd_s;

	// decoded transceiver mode
	typedef struct packed {
		logic active;
		logic wake_capable;
		logic rx_only;
		logic normal;
		logic selective_wake;
	} can_dec_s;

endpackage : wdbus_pkg

// ---- rtl/wdbus_regs.svh ----
// Purpose: offsets, field positions, reset values for watchdog and bus-mode registers
// Assumes: 7-bit register addresses, 8-bit data
// Notes:   definitions only
`ifndef WDBUS_REGS_SVH
`define WDBUS_REGS_SVH

`define WATCHDOG_CONTROL_ADDR        7'h03
`define BUS_MODE_ADDR       7'h04
`define BUS_PEAK_ADDR       7'h05
`define EXT_WAKE_ADDR       7'h07

`define WATCHDOG_CONTROL_POR         8'h14
`define WATCHDOG_CONTROL_WMASK       8'hF7
`define WATCHDOG_PERIOD_FIELD_RESTART    3'h4
`define WD_CHECKSUM_BIT     7
`define WD_STOP_DIS_BIT     6
`define WD_TYPE_BIT         5
`define WD_BUS_WAKE_BIT     4

`define BUS_MODE_POR        8'h00
`define BUS_MODE_WMASK      8'h07
`define BUS_PEAK_POR        8'h00
`define BUS_PEAK_BIT        5

`define EXT_WAKE_POR        8'h07
`define EXT_WAKE_WMASK      8'hA7
`define EXT_WAKE_FS_SET     8'h07
`define EXT_WAKE_FS_KEEP    8'hA0
`define INT_GLOBAL_BIT      7

`define CAN_MODE_WAKE       2'h1
`define CAN_MODE_RX         2'h2
`define CAN_MODE_NORMAL     2'h3

`endif

// ---- sim/wdbus_ctrl_regs_props.sv ----
// Purpose: assertions on the watchdog and bus-mode register bank
// Assumes: one clock, sync active-low reset
// Notes:   bound to the top module at the foot
`timescale 1ns/10ps
module wdbus_ctrl_regs_props
	import wdbus_pkg::*;
(
	input wire logic       core_clk_i,
	input wire logic       rst_n_i,
	input wire spi_req_s   spi_req_i,
	input wire logic [7:0] spi_rdata_o,
	input wire logic       spi_fail_o,
	input wire sbc_mode_e  sbc_mode_i,
	input wire logic       soft_reset_i,
	input wire logic       restart_entry_i,
	input wire logic       sleep_entry_i,
	input wire logic       stop_entry_i,
	input wire logic       failsafe_entry_i,
	input wire logic       system_error_flag_i,
	input wire logic       wake_event_i,
	input wire can_dec_s   can_dec_o,
	input wire logic       active_peak_threshold_sel_o,
	input wire logic       int_request_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// nothing else competes with a mode step in this cycle
	logic quiet;
	assign quiet = !soft_reset_i && !restart_entry_i && !failsafe_entry_i && !spi_req_i.wr;
	// peak write outside any reload cycle
	sequence peak_wr_s;
		spi_req_i.wr && spi_req_i.addr == 7'h05 && !soft_reset_i && !restart_entry_i;
	endsequence
	chk_peak_write: assert property (
		peak_wr_s ##0 sbc_mode_i inside {SBC_INIT, SBC_NORMAL}
		|=> active_peak_threshold_sel_o == $past(spi_req_i.wdata[5])) else $error("peak write lost");
	chk_peak_stop: assert property (
		peak_wr_s ##0 sbc_mode_i == SBC_STOP |=> $stable(active_peak_threshold_sel_o) && !spi_fail_o)
		else $error("peak changed in stop");
	chk_sleep_normal: assert property (
		sleep_entry_i && quiet && !system_error_flag_i && can_dec_o.normal
		|=> can_dec_o.wake_capable && $stable(can_dec_o.selective_wake)) else $error("sleep step wrong");
	chk_stop_rxonly: assert property (
		stop_entry_i && quiet && can_dec_o.rx_only |=> can_dec_o.rx_only) else $error("stop left rx");
	chk_failsafe_wake: assert property (
		failsafe_entry_i && !soft_reset_i && !restart_entry_i |=> can_dec_o.wake_capable)
		else $error("failsafe not wake capable");
	chk_rsvd_read: assert property (
		spi_req_i.rd && spi_req_i.addr == 7'h04 |=> spi_rdata_o[7:3] == 5'h00) else $error("reserved set");
	chk_soft_clear: assert property (
		soft_reset_i |=> !active_peak_threshold_sel_o && !can_dec_o.active) else $error("soft reset kept");
	chk_int_wake: assert property (
		wake_event_i |=> int_request_o) else $error("wake gave no int");
endmodule : wdbus_ctrl_regs_props

bind wdbus_ctrl_regs wdbus_ctrl_regs_props u_props (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .spi_req_i(spi_req_i), .spi_rdata_o(spi_rdata_o),
	.spi_fail_o(spi_fail_o), .sbc_mode_i(sbc_mode_i), .soft_reset_i(soft_reset_i),
	.restart_entry_i(restart_entry_i), .sleep_entry_i(sleep_entry_i), .stop_entry_i(stop_entry_i),
	.failsafe_entry_i(failsafe_entry_i), .system_error_flag_i(system_error_flag_i),
	.wake_event_i(wake_event_i), .can_dec_o(can_dec_o),
	.active_peak_threshold_sel_o(active_peak_threshold_sel_o), .int_request_o(int_request_o));

// ---- sim/wdbus_ctrl_regs_tb.sv ----
// Purpose: directed register tests of the watchdog and bus-mode bank
// Assumes: host model drives all frames
// Notes:   event strobes: soft, restart, sleep, stop, failsafe, wake, status, can wake
`timescale 1ns/10ps
module wdbus_ctrl_regs_tb
	import wdbus_pkg::*;
;
	logic       clk, rst_n;
	spi_req_s   req;
	logic [7:0] rdata, q;
	logic [7:0] ev;
	logic [2:0] rmode;
	logic       fail, peak, intr;
	logic       serr, wdhi, run, lwin;
	logic [7:0] ext;
	sbc_mode_e  mode;
	wd_cfg_s    cfg;
	can_dec_s   dec;
	wd_hw_upd_s hw;
	int         n_mismatch, total_checks, cyc;
	// start modes and expected results of the low-power steps
	localparam logic [7:0] lp_start[5] = '{8'h07, 8'h06, 8'h06, 8'h04, 8'h01};
	localparam int         lp_ev[5]    = '{2, 3, 2, 2, 3};
	localparam logic [7:0] lp_exp[5]   = '{8'h05, 8'h06, 8'h05, 8'h04, 8'h01};

	wdbus_ctrl_regs uut (
		.core_clk_i(clk), .rst_n_i(rst_n), .spi_req_i(req), .spi_rdata_o(rdata), .spi_fail_o(fail),
		.sbc_mode_i(mode), .soft_reset_i(ev[0]), .restart_entry_i(ev[1]), .restart_can_mode_i(rmode),
		.sleep_entry_i(ev[2]), .stop_entry_i(ev[3]), .failsafe_entry_i(ev[4]), .system_error_flag_i(serr),
		.stop_watchdog_disable_hi_i(wdhi), .can_wake_i(ev[7]), .wake_event_i(ev[5]), .status_event_i(ev[6]),
		.wd_hw_upd_i(hw), .wd_cfg_o(cfg), .watchdog_run_o(run), .watchdog_long_window_o(lwin), .can_dec_o(dec),
		.active_peak_threshold_sel_o(peak), .external_wake_source_o(ext), .int_request_o(intr));
	wdbus_host_model host (.spi_rdata_i(rdata), .core_clk_i(clk), .spi_req_o(req));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		host.xfer(1'b0, a, 8'h00, q);
		check(q, exp);
	endtask : rd
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic pulse(input int i);
		@(posedge clk);
		#1 ev[i] = 1'b1;
		@(posedge clk);
		#1 ev[i] = 1'b0;
	endtask : pulse
	task stop_test;
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard, far above the roughly 150 cycles the sequence needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		{rst_n, ev, rmode, hw, serr, wdhi, n_mismatch, total_checks, cyc} = '0;
		mode = SBC_NORMAL;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		rd(7'h03, 8'h14);
		rd(7'h04, 8'h00);
		rd(7'h05, 8'h00);
		rd(7'h10, 8'h00);
		host.wd_write(7'h6F);
		rd(7'h03, 8'hE7);
		check({4'h0, cfg.stop_disable, cfg.parity_ok, cfg.window_type, cfg.start_on_bus_wake}, 8'h0E);
		wr(7'h03, 8'h20);
		check({4'h0, cfg.stop_disable, cfg.parity_ok, cfg.window_type, cfg.start_on_bus_wake}, 8'h02);
		// timer field updated by hardware must read back
		@(posedge clk);
		#1 hw = {1'b1, 3'h6, 4'h0};
		@(posedge clk);
		#1 hw = '0;
		rd(7'h03, 8'h26);
		check({5'h00, cfg.period}, 8'h06);
		wr(7'h05, 8'hFF);
		rd(7'h05, 8'h20);
		check({7'h00, peak}, 8'h01);
		mode = SBC_STOP;
		wr(7'h05, 8'h00);
		check({7'h00, fail}, 8'h00);
		rd(7'h05, 8'h20);
		// outside init, normal and stop the refused write raises the failure pulse
		mode = SBC_SLEEP;
		wr(7'h05, 8'h00);
		check({7'h00, fail}, 8'h01);
		rd(7'h05, 8'h20);
		mode = SBC_NORMAL;
		for (int m = 0; m < 8; m++) begin
			wr(7'h04, 8'(m));
			rd(7'h04, 8'(m));
			check({3'h0, dec}, {3'h0, m[1:0] != 2'h0, m[1:0] == 2'h1, m[1:0] == 2'h2, m[1:0] == 2'h3, m[2]});
		end
		for (int k = 0; k < 5; k++) begin
			wr(7'h04, lp_start[k]);
			pulse(lp_ev[k]);
			rd(7'h04, lp_exp[k]);
		end
		// a pending system error keeps normal mode on sleep entry
		serr = 1'b1;
		wr(7'h04, 8'h03);
		pulse(2);
		rd(7'h04, 8'h03);
		serr = 1'b0;
		wr(7'h04, 8'h07);
		wr(7'h07, 8'hA0);
		pulse(4);
		rd(7'h04, 8'h05);
		rd(7'h07, 8'hA7);
		check(ext, 8'hA7);
		pulse(6);
		check({7'h00, intr}, 8'h01);
		wr(7'h07, 8'h07);
		pulse(6);
		check({7'h00, intr}, 8'h00);
		pulse(5);
		check({7'h00, intr}, 8'h01);
		// stop mode: watchdog halts only with both disable bits, a bus wake restarts it
		mode = SBC_STOP;
		wdhi = 1'b1;
		host.wd_write(7'h40);
		pulse(7);
		check({6'h00, lwin, run}, 8'h00);
		wdhi = 1'b0;
		host.wd_write(7'h50);
		check({6'h00, lwin, run}, 8'h01);
		wdhi = 1'b1;
		pulse(7);
		check({6'h00, lwin, run}, 8'h03);
		mode = SBC_NORMAL;
		host.wd_write(7'h6F);
		check({6'h00, lwin, run}, 8'h01);
		rmode = 3'h2;
		pulse(1);
		rd(7'h03, 8'hA4);
		rd(7'h04, 8'h02);
		rd(7'h05, 8'h20);
		pulse(0);
		rd(7'h03, 8'h14);
		rd(7'h05, 8'h00);
		stop_test();
	end
endmodule : wdbus_ctrl_regs_tb

// ---- sim/wdbus_host_model.sv ----
// Purpose: host controller issuing register frames
// Assumes: frames decoded to one-cycle strobes, read data a cycle later
// Notes:   idle lines carry the inverse of the last frame, never a stale copy
`timescale 1ns/10ps
module wdbus_host_model
	import wdbus_pkg::*;
(
	input  wire logic [7:0] spi_rdata_i,
	input  wire logic       core_clk_i,
	output spi_req_s        spi_req_o
);
	initial spi_req_o = '0;
	// one frame, held until the taking edge, data picked up after it
	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk_i);
		#1 spi_req_o = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge core_clk_i);
		#1 spi_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		q = spi_rdata_i;
	endtask : xfer
	// checksum bit chosen so the stored byte has even parity; reserved bit 3 is never stored
	task automatic wd_write(input logic [6:0] v);
		logic [7:0] q;
		xfer(1'b1, 7'h03, {^(v & 7'h77), v}, q);
	endtask : wd_write
endmodule : wdbus_host_model
